// ==== src/cfg_cmd_defines.svh ====
`ifndef CFG_CMD_DEFINES_SVH
`define CFG_CMD_DEFINES_SVH

// opcodes
`define OP_PART_READ 8'h31
`define OP_BOR_READ 8'h15
`define OP_BOR_WRITE 8'h11
`define OP_ID_READ 8'h9f
`define OP_WRITE_ENABLE_CMD 8'h06
`define OP_STATUS_READ 8'h05
`define OP_READY_READ 8'h04
`define OP_SOFT_RESET 8'h7c
`define OP_ARRAY_WRITE 8'h02
`define OP_STATUS_WRITE 8'h01
`define OP_EXT_WRITE 8'h22
`define OP_LOCK 8'h82
`define OP_PART_WRITE 8'h32
`define OP_BOUNDARY 8'h34
`define OP_FREEZE 8'h37

// brown-out register fields
`define BOR_EN_BIT 5
`define BOR_LVL_MSB 4
`define BOR_RESET 8'h00
`define BOR_MASK 8'h3f

// partition select bits within the 16-bit address
`define PART_SEL_HI 11
`define PART_SEL_LO 10

// status byte 1 bit positions
`define ST1_BUSY_BIT 0
`define ST1_WEL_BIT 1
`define ST1_LOCKOUT_BIT 2

// identification bytes (values arbitrary)
`define ID_MFR 8'h5a
`define ID_DEV1 8'h63
`define ID_DEV2 8'h11
`define ID_EDI_LEN 8'h01
`define ID_REV 8'h07

// timing, ns and cycles at 40 MHz (25 ns)
`define CLK_NS 25
`define DETECT_NS 1000
`define DETECT_CYC ((`DETECT_NS + `CLK_NS - 1) / `CLK_NS)
`define NVWRITE_NS 4000000
`define NVWRITE_CYC (`NVWRITE_NS / `CLK_NS)

`endif

// ==== src/cfg_cmd_pkg.sv ====
package cfg_cmd_pkg;

  typedef enum logic [5:0] {
    ST_OPCODE = 6'h01,
    ST_ADDR = 6'h02,
    ST_DATA_IN = 6'h04,
    ST_SHIFT_OUT = 6'h08,
    ST_DONE = 6'h10,
    ST_IGNORE = 6'h20
  } frame_state_e;

  typedef enum logic [2:0] {
    NV_IDLE = 3'h1,
    NV_DETECT = 3'h2,
    NV_WRITE = 3'h4
  } nv_state_e;

  typedef struct packed {
    logic sel_n;
    logic sck;
    logic mosi;
  } spi_pins_s;

endpackage

// ==== src/pin_sync.sv ====
`timescale 1ns/1ps
// two-stage synchroniser with edge detection on the stable stage
module pin_sync #(
  parameter int WIDTH = 3,
  parameter logic [WIDTH-1:0] RST_VAL = '1
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // pins
  input wire logic [WIDTH-1:0] pin_in,
  // synchronised
  output logic [WIDTH-1:0] level,
  output logic [WIDTH-1:0] rise,
  output logic [WIDTH-1:0] fall
);
  logic [WIDTH-1:0] meta_q;
  logic [WIDTH-1:0] stab_q;
  logic [WIDTH-1:0] prev_q;
  logic [WIDTH-1:0] meta_d;
  logic [WIDTH-1:0] stab_d;
  logic [WIDTH-1:0] prev_d;

  always_comb
  begin
    meta_d = pin_in;
    stab_d = meta_q;
    prev_d = stab_q;
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      // reset to the idle pin levels so no false edge follows reset
      meta_q <= RST_VAL;
      stab_q <= RST_VAL;
      prev_q <= RST_VAL;
    end
    else
    begin
      meta_q <= meta_d;
      stab_q <= stab_d;
      prev_q <= prev_d;
    end
  end

  assign level = stab_q;
  assign rise = stab_q & ~prev_q;
  assign fall = ~stab_q & prev_q;
endmodule

// ==== src/cfg_cmd_core.sv ====
`timescale 1ns/1ps
`include "cfg_cmd_defines.svh"
// Overview of operation
// - partition read: opcode, 16-bit address, then register data shifted out
// - partition read works regardless of the freeze flag
// - register chosen by address bits 11-10; one register per read
// - all other fourteen address bits are ignored
// - when guard enabled, low supply through detect time cancels the started write
// - guard cancels the brown-out write, the only nonvolatile write the core starts
// - lockout flag at status byte 1 bit 2 set on cancelled write
// - lockout flag cleared by power-on, nonvolatile opcode, or soft reset
// - busy reads one during detection; cleared with lockout set if cancelled
// - brown-out register: bits 7-6 zero, bit 5 enable, bits 4-0 level
// - brown-out read: opcode then the 8-bit value shifted out
// - brown-out write needs write-enable latch; refused when protect pin enabled and asserted
// - brown-out write: opcode, 8-bit value; chip-select rise starts write
// - during the write only status reads accepted; latch cleared at completion
// - chip-select rise before 16 bits aborts the write
// - identification: maker byte, then two device bytes
// - fourth byte length 01h, one revision byte, then output released
// - chip-select rise at any point ends identification and releases output
// - second byte family and density, third byte sub-code and variant
module cfg_cmd_core #(
  parameter int DETECT_CYCLES = `DETECT_CYC,
  parameter int WRITE_CYCLES = `NVWRITE_CYC,
  parameter logic [7:0] ID_MFR = `ID_MFR,
  parameter logic [7:0] ID_DEV1 = `ID_DEV1,
  parameter logic [7:0] ID_DEV2 = `ID_DEV2,
  parameter logic [7:0] ID_REV = `ID_REV
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // serial pins
  input wire cfg_cmd_pkg::spi_pins_s spi_in,
  output logic so_out,
  output logic so_oe,
  // protection and supply
  input wire logic wp_n_pin,
  input wire logic supply_low,
  input wire logic protect_pin_enable,
  input wire logic protection_freeze_flag,
  // partition register contents
  input wire logic [31:0] partition_register,
  // state views
  output logic [7:0] brownout_threshold_config,
  output logic write_lockout_flag,
  output logic busy_flag,
  output logic write_enable_latch,
  output logic nv_write_pulse
);
  logic [2:0] pin_lvl;
  logic [2:0] pin_rise;
  logic [2:0] pin_fall;
  logic sel_n;
  logic sel_rise;
  logic sck_rise;
  logic sck_fall;
  logic mosi;
  logic wp_meta_q;
  logic wp_sync_q;
  logic low_meta_q;
  logic low_sync_q;

  pin_sync #(
    .WIDTH(3),
    .RST_VAL(3'h4)
  ) u_sync (
    .clk_sys(clk_sys),
    .nrst(nrst),
    .pin_in({spi_in.sel_n, spi_in.sck, spi_in.mosi}),
    .level(pin_lvl),
    .rise(pin_rise),
    .fall(pin_fall)
  );

  assign sel_n = pin_lvl[2];
  assign sel_rise = pin_rise[2];
  assign sck_rise = pin_rise[1] & ~pin_lvl[2];
  assign sck_fall = pin_fall[1] & ~pin_lvl[2];
  assign mosi = pin_lvl[0];

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      wp_meta_q <= 1'b1;
      wp_sync_q <= 1'b1;
      low_meta_q <= 1'b0;
      low_sync_q <= 1'b0;
    end
    else
    begin
      wp_meta_q <= wp_n_pin;
      wp_sync_q <= wp_meta_q;
      low_meta_q <= supply_low;
      low_sync_q <= low_meta_q;
    end
  end

  // frame state
  cfg_cmd_pkg::frame_state_e st_q, st_d;
  logic [7:0] op_q, op_d;
  logic [15:0] sh_q, sh_d;
  logic [5:0] cnt_q, cnt_d;
  logic [39:0] out_q, out_d;
  logic [5:0] out_left_q, out_left_d;
  logic so_q, so_d;
  logic oe_q, oe_d;
  // nonvolatile state
  cfg_cmd_pkg::nv_state_e nv_q, nv_d;
  logic [7:0] bor_q, bor_d;
  logic [7:0] pend_q, pend_d;
  logic wel_q, wel_d;
  logic lock_q, lock_d;
  logic armed_q, armed_d;
  logic [31:0] tmr_q, tmr_d;
  logic [7:0] op_next;
  logic nv_op;
  logic [7:0] part_byte;
  logic [7:0] status1;

  assign op_next = {op_q[6:0], mosi};
  assign nv_op = (op_next == `OP_ARRAY_WRITE) || (op_next == `OP_STATUS_WRITE)
    || (op_next == `OP_EXT_WRITE) || (op_next == `OP_LOCK)
    || (op_next == `OP_PART_WRITE) || (op_next == `OP_BOUNDARY)
    || (op_next == `OP_FREEZE) || (op_next == `OP_BOR_WRITE);

  always_comb
  begin
    case ({sh_q[`PART_SEL_HI - 1], sh_q[`PART_SEL_LO - 1]})
      2'b00: part_byte = partition_register[7:0];
      2'b01: part_byte = partition_register[15:8];
      2'b10: part_byte = partition_register[23:16];
      default: part_byte = partition_register[31:24];
    endcase
  end

  always_comb
  begin
    status1 = 8'h00;
    status1[`ST1_BUSY_BIT] = (nv_q != cfg_cmd_pkg::NV_IDLE);
    status1[`ST1_WEL_BIT] = wel_q;
    status1[`ST1_LOCKOUT_BIT] = lock_q;
  end

  // frame decode
  always_comb
  begin
    st_d = st_q;
    op_d = op_q;
    sh_d = sh_q;
    cnt_d = cnt_q;
    out_d = out_q;
    out_left_d = out_left_q;
    so_d = so_q;
    oe_d = oe_q;
    pend_d = pend_q;
    armed_d = armed_q;
    if (sel_n)
    begin
      st_d = cfg_cmd_pkg::ST_OPCODE;
      cnt_d = 6'h00;
      oe_d = 1'b0;
      armed_d = 1'b0;
    end
    else if (sck_rise)
    begin
      case (st_q)
        cfg_cmd_pkg::ST_OPCODE:
        begin
          op_d = op_next;
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'h07)
          begin
            cnt_d = 6'h00;
            if (nv_q != cfg_cmd_pkg::NV_IDLE && op_next != `OP_STATUS_READ
              && op_next != `OP_READY_READ)
              st_d = cfg_cmd_pkg::ST_IGNORE;
            else if (op_next == `OP_PART_READ)
              st_d = cfg_cmd_pkg::ST_ADDR;
            else if (op_next == `OP_BOR_READ)
            begin
              st_d = cfg_cmd_pkg::ST_SHIFT_OUT;
              out_d = {bor_q & `BOR_MASK, 32'h0};
              out_left_d = 6'd8;
            end
            else if (op_next == `OP_ID_READ)
            begin
              st_d = cfg_cmd_pkg::ST_SHIFT_OUT;
              out_d = {ID_MFR, ID_DEV1, ID_DEV2, `ID_EDI_LEN, ID_REV};
              out_left_d = 6'd40;
            end
            else if (op_next == `OP_STATUS_READ || op_next == `OP_READY_READ)
            begin
              st_d = cfg_cmd_pkg::ST_SHIFT_OUT;
              out_d = {status1, 32'h0};
              out_left_d = 6'd8;
            end
            // brown-out write takes one data byte
            else if (op_next == `OP_BOR_WRITE)
              st_d = cfg_cmd_pkg::ST_DATA_IN;
            else
              st_d = cfg_cmd_pkg::ST_DONE;
          end
        end
        cfg_cmd_pkg::ST_ADDR:
        begin
          sh_d = {sh_q[14:0], mosi};
          cnt_d = cnt_q + 6'h01;
          if (cnt_q == 6'h0f)
          begin
            st_d = cfg_cmd_pkg::ST_SHIFT_OUT;
            out_left_d = 6'd8;
            out_d = {part_byte, 32'h0};
          end
        end
        cfg_cmd_pkg::ST_DATA_IN:
        begin
          sh_d = {sh_q[14:0], mosi};
          // saturate so an overlong frame never re-arms the write
          cnt_d = (cnt_q == 6'h3f) ? cnt_q : cnt_q + 6'h01;
          armed_d = 1'b0;
          // armed only on exactly 16 bits
          if (cnt_q == 6'h07)
          begin
            pend_d = {sh_q[6:0], mosi};
            armed_d = 1'b1;
          end
        end
        default:
        begin
          st_d = st_q;
        end
      endcase
    end
    else if (sck_fall && st_q == cfg_cmd_pkg::ST_SHIFT_OUT)
    begin
      if (out_left_q == 6'h00)
      begin
        oe_d = 1'b0;
        st_d = cfg_cmd_pkg::ST_DONE;
      end
      else
      begin
        so_d = out_q[39];
        oe_d = 1'b1;
        out_d = {out_q[38:0], 1'b0};
        out_left_d = out_left_q - 6'h01;
      end
    end
  end

  // nonvolatile write sequencer
  always_comb
  begin
    nv_d = nv_q;
    bor_d = bor_q;
    wel_d = wel_q;
    lock_d = lock_q;
    tmr_d = tmr_q;
    nv_write_pulse = 1'b0;
    if (sck_rise && st_q == cfg_cmd_pkg::ST_OPCODE && cnt_q == 6'h07)
    begin
      // nonvolatile opcode or soft reset clears lockout
      if (nv_op || op_next == `OP_SOFT_RESET)
        lock_d = 1'b0;
      if (op_next == `OP_WRITE_ENABLE_CMD && nv_q == cfg_cmd_pkg::NV_IDLE)
        wel_d = 1'b1;
      if (op_next == `OP_SOFT_RESET && nv_q == cfg_cmd_pkg::NV_IDLE)
        wel_d = 1'b0;
    end
    case (nv_q)
      cfg_cmd_pkg::NV_IDLE:
      begin
        if (sel_rise && armed_q && wel_q && !(protect_pin_enable && !wp_sync_q))
        begin
          tmr_d = 32'h0;
          if (bor_q[`BOR_EN_BIT])
            nv_d = cfg_cmd_pkg::NV_DETECT;
          else
            nv_d = cfg_cmd_pkg::NV_WRITE;
        end
      end
      cfg_cmd_pkg::NV_DETECT:
      begin
        tmr_d = low_sync_q ? tmr_q + 32'h1 : 32'h0;
        if (low_sync_q && tmr_q == 32'(DETECT_CYCLES - 1))
        begin
          nv_d = cfg_cmd_pkg::NV_IDLE;
          lock_d = 1'b1;
          wel_d = 1'b0;
        end
        else if (!low_sync_q)
          nv_d = cfg_cmd_pkg::NV_WRITE;
      end
      cfg_cmd_pkg::NV_WRITE:
      begin
        tmr_d = tmr_q + 32'h1;
        if (tmr_q == 32'(WRITE_CYCLES - 1))
        begin
          bor_d = pend_q & `BOR_MASK;
          wel_d = 1'b0;
          nv_write_pulse = 1'b1;
          nv_d = cfg_cmd_pkg::NV_IDLE;
        end
      end
      default:
      begin
        nv_d = cfg_cmd_pkg::NV_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_sys or negedge nrst)
  begin
    if (!nrst)
    begin
      st_q <= cfg_cmd_pkg::ST_OPCODE;
      op_q <= 8'h00;
      sh_q <= 16'h0000;
      cnt_q <= 6'h00;
      out_q <= 40'h0;
      out_left_q <= 6'h00;
      so_q <= 1'b0;
      oe_q <= 1'b0;
      pend_q <= 8'h00;
      armed_q <= 1'b0;
      nv_q <= cfg_cmd_pkg::NV_IDLE;
      bor_q <= `BOR_RESET;
      wel_q <= 1'b0;
      lock_q <= 1'b0;
      tmr_q <= 32'h0;
    end
    else
    begin
      st_q <= st_d;
      op_q <= op_d;
      sh_q <= sh_d;
      cnt_q <= cnt_d;
      out_q <= out_d;
      out_left_q <= out_left_d;
      so_q <= so_d;
      oe_q <= oe_d;
      pend_q <= pend_d;
      armed_q <= armed_d;
      nv_q <= nv_d;
      bor_q <= bor_d;
      wel_q <= wel_d;
      lock_q <= lock_d;
      tmr_q <= tmr_d;
    end
  end

  assign so_out = so_q;
  assign so_oe = oe_q;
  assign brownout_threshold_config = bor_q;
  assign write_lockout_flag = lock_q;
  assign busy_flag = (nv_q != cfg_cmd_pkg::NV_IDLE);
  assign write_enable_latch = wel_q;
endmodule

// ==== dv/cfg_cmd_asserts.sv ====
`timescale 1ns/1ps
module cfg_cmd_asserts #(
  parameter int DETECT_CYCLES = 40,
  parameter int WRITE_CYCLES = 20
) (
  // clock and reset
  input wire logic clk_sys,
  input wire logic nrst,
  // pins
  input wire cfg_cmd_pkg::spi_pins_s spi_in,
  input wire logic so_oe,
  input wire logic supply_low,
  // state views
  input wire logic [7:0] brownout_threshold_config,
  input wire logic write_lockout_flag,
  input wire logic busy_flag,
  input wire logic write_enable_latch
);
  localparam int BUSY_MAX = DETECT_CYCLES + WRITE_CYCLES + 8;
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!nrst);
  chk_bor_top_zero: assert property (brownout_threshold_config[7:6] == 2'b00)
    else $error("brown-out bits 7-6 not zero");
  chk_bor_busy_update: assert property ($changed(brownout_threshold_config) |-> $past(busy_flag))
    else $error("brown-out register changed outside a write");
  chk_write_needs_latch: assert property ($rose(busy_flag) |-> $past(write_enable_latch))
    else $error("write started without latch");
  chk_write_after_desel: assert property ($rose(busy_flag) |-> spi_in.sel_n)
    else $error("write started while selected");
  chk_busy_bounded: assert property ($rose(busy_flag) |-> ##[1:BUSY_MAX] !busy_flag)
    else $error("busy held too long");
  chk_latch_cleared: assert property ($fell(busy_flag) |-> ##[0:2] !write_enable_latch)
    else $error("latch not cleared after write");
  chk_lockout_busy: assert property ($rose(write_lockout_flag) |-> $past(busy_flag) ##[0:2] !busy_flag)
    else $error("lockout set without detect phase");
  chk_lockout_supply: assert property ($rose(write_lockout_flag) |-> supply_low)
    else $error("lockout set with good supply");
  chk_desel_release: assert property (spi_in.sel_n [*8] |-> !so_oe)
    else $error("output driven while deselected");
endmodule

// ==== dv/spi_host.sv ====
`timescale 1ns/1ps
module spi_host (
  // clock
  input wire logic clk_sys,
  // pins
  output cfg_cmd_pkg::spi_pins_s pins,
  input wire logic so_out,
  input wire logic so_oe
);
  logic sel_q = 1'b1;
  logic sck_q = 1'b0;
  logic bit_q = 1'b0;
  logic idle_q = 1'b0;
  // released data line toggles so stale values never look valid
  always @(posedge clk_sys)
    idle_q <= ~idle_q;
  assign pins = '{sel_n: sel_q, sck: sck_q, mosi: sel_q ? idle_q : bit_q};
  task automatic frame(input logic [63:0] tx, input int n, output logic [63:0] rx,
                       output logic oe);
    rx = '0;
    oe = 1'b0;
    @(posedge clk_sys);
    sel_q <= 1'b0;
    for (int i = 0; i < n; i++)
    begin
      bit_q <= tx[63-i];
      repeat (4) @(posedge clk_sys);
      sck_q <= 1'b1;
      repeat (4) @(posedge clk_sys);
      // a released output shows the inverse of its last level
      rx = {rx[62:0], so_oe ? so_out : ~so_out};
      oe = so_oe;
      sck_q <= 1'b0;
    end
    repeat (4) @(posedge clk_sys);
    sel_q <= 1'b1;
    repeat (8) @(posedge clk_sys);
  endtask
endmodule

// ==== dv/tb.sv ====
`timescale 1ns/1ps
`include "cfg_cmd_defines.svh"
module tb;
  localparam int DET = 200;
  localparam int WR = 400;
  logic clk_sys = 1'b0;
  logic nrst = 1'b0;
  logic wp_n_pin = 1'b1;
  logic supply_low = 1'b0;
  logic protect_pin_enable = 1'b0;
  logic protection_freeze_flag = 1'b0;
  logic [31:0] partition_register = 32'ha1b2c3d4;
  cfg_cmd_pkg::spi_pins_s spi_in;
  logic so_out, so_oe, write_lockout_flag, busy_flag, write_enable_latch, nv_write_pulse;
  int commits = 0;
  logic [7:0] brownout_threshold_config;
  logic [63:0] rx;
  logic oe;
  int fails = 0;
  int comparisons = 0;
  logic [7:0] ops [9] = '{8'h02, 8'h01, 8'h22, 8'h82, 8'h32, 8'h34, 8'h37, 8'h11, 8'h7c};
  always #12.5 clk_sys = ~clk_sys;
  spi_host i_host (.clk_sys, .pins(spi_in), .so_out, .so_oe);
  cfg_cmd_core #(.DETECT_CYCLES(DET), .WRITE_CYCLES(WR)) i_dut (.clk_sys, .nrst, .spi_in,
    .so_out, .so_oe, .wp_n_pin, .supply_low, .protect_pin_enable, .protection_freeze_flag,
    .partition_register, .brownout_threshold_config, .write_lockout_flag, .busy_flag,
    .write_enable_latch, .nv_write_pulse);
  always @(posedge clk_sys)
    if (nv_write_pulse === 1'b1)
      commits <= commits + 1;
  task automatic chk(input logic [39:0] seen, input logic [39:0] exp);
    comparisons++;
    if (seen !== exp)
    begin
      fails++;
      $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic end_sim();
    $display("fails=%0d comparisons=%0d", fails, comparisons);
    if (fails == 0 && comparisons > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask
  task automatic cmd(input logic [63:0] tx, input int n);
    i_host.frame(tx, n, rx, oe);
  endtask
  task automatic wait_idle();
    for (int i = 0; i < 800 && busy_flag !== 1'b0; i++)
      @(posedge clk_sys);
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic bor_write(input logic [7:0] v);
    cmd({8'h06, 56'h0}, 8);
    cmd({8'h11, v, 48'h0}, 16);
    wait_idle();
  endtask
  // about 10k cycles expected; limit leaves wide margin
  initial
  begin
    #2000000;
    fails++;
    end_sim();
  end
  initial
  begin
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (4) @(posedge clk_sys);
    cmd({8'h9f, 56'h0}, 56);
    chk(rx[47:8], {`ID_MFR, `ID_DEV1, `ID_DEV2, 8'h01, `ID_REV});
    chk(oe, 1'b0);
    cmd({8'h9f, 56'h0}, 20);
    chk(oe, 1'b1);
    chk(so_oe, 1'b0);
    $display("test id done");
    for (int i = 0; i < 4; i++)
    begin
      protection_freeze_flag <= i[1];
      cmd({8'h31, (i[0] ? 16'hf3ff : 16'h0000) | 16'(i << 10), 40'h0}, 32);
      chk(rx[7:0], partition_register[8*i +: 8]);
    end
    $display("test partition done");
    bor_write(8'hff);
    chk({brownout_threshold_config, write_enable_latch}, {8'h3f, 1'b0});
    cmd({8'h15, 56'h0}, 16);
    chk(rx[7:0], 8'h3f);
    cmd({8'h11, 8'h25, 48'h0}, 16);
    wait_idle();
    protect_pin_enable <= 1'b1;
    wp_n_pin <= 1'b0;
    bor_write(8'h25);
    protect_pin_enable <= 1'b0;
    wp_n_pin <= 1'b1;
    cmd({8'h06, 56'h0}, 8);
    cmd({8'h11, 8'h25, 48'h0}, 15);
    wait_idle();
    chk(brownout_threshold_config, 8'h3f);
    cmd({8'h06, 56'h0}, 8);
    cmd({8'h11, 8'h2a, 48'h0}, 16);
    cmd({8'h05, 56'h0}, 16);
    chk(rx[1:0], 2'b11);
    cmd({8'h04, 56'h0}, 16);
    chk(rx[0], 1'b1);
    cmd({8'h15, 56'h0}, 16);
    chk(oe, 1'b0);
    wait_idle();
    chk({brownout_threshold_config, write_enable_latch}, {8'h2a, 1'b0});
    chk(commits, 32'd2);
    $display("test brown-out done");
    for (int i = 0; i < 9; i++)
    begin
      supply_low <= 1'b1;
      cmd({8'h06, 56'h0}, 8);
      cmd({8'h11, 8'h33, 48'h0}, 16);
      // guard is enabled here, so the lockout bit is meaningful
      cmd({8'h05, 56'h0}, 16);
      chk(rx[0], 1'b1);
      wait_idle();
      supply_low <= 1'b0;
      chk(brownout_threshold_config, 8'h2a);
      cmd({8'h05, 56'h0}, 16);
      chk(rx[2:0], 3'b100);
      cmd({ops[i], 56'h0}, 8);
      chk(write_lockout_flag, 1'b0);
    end
    chk(commits, 32'd2);
    $display("test lockout done");
    supply_low <= 1'b1;
    cmd({8'h06, 56'h0}, 8);
    cmd({8'h11, 8'h33, 48'h0}, 16);
    wait_idle();
    supply_low <= 1'b0;
    chk(write_lockout_flag, 1'b1);
    nrst <= 1'b0;
    repeat (20) @(posedge clk_sys);
    nrst <= 1'b1;
    repeat (2) @(posedge clk_sys);
    chk({write_lockout_flag, busy_flag, write_enable_latch, so_oe}, 4'h0);
    $display("test reset done");
    end_sim();
  end
endmodule
bind cfg_cmd_core cfg_cmd_asserts #(.DETECT_CYCLES(DETECT_CYCLES), .WRITE_CYCLES(WRITE_CYCLES))
  i_chk (.clk_sys(clk_sys), .nrst(nrst), .spi_in(spi_in), .so_oe(so_oe),
  .supply_low(supply_low), .brownout_threshold_config(brownout_threshold_config),
  .write_lockout_flag(write_lockout_flag), .busy_flag(busy_flag),
  .write_enable_latch(write_enable_latch));
